// ===== logic/fbcs_defs.svh
// Constants for the flash burst configuration sequencer
`ifndef FBCS_DEFS_SVH
`define FBCS_DEFS_SVH
`define FBCS_CFG_RESET        16'h8000
`define FBCS_CTL_IDLE         6'h3e
`define FBCS_CFG_WRITE_MASK   16'hbbcf
`define FBCS_LEN_FOUR         3'h1
`define FBCS_LEN_EIGHT        3'h2
`define FBCS_LEN_CONT         3'h7
`define FBCS_LAT_MIN          3'h2
`define FBCS_LAT_MAX          3'h6
`define FBCS_LAT_BIAS         4'h2
`define FBCS_CMD_READ_ARRAY   8'hff
`define FBCS_CMD_SIGNATURE    8'h90
`define FBCS_CMD_CFG_SETUP    8'h60
`define FBCS_SIG_MAKER_ADDR   3'h0
`define FBCS_SIG_DEVICE_ADDR  3'h1
`define FBCS_SIG_CFG_ADDR     3'h5
`define FBCS_WAIT_EDGES       4'h2
`endif

// ===== logic/fbcs_pkg.sv
// Types for the flash burst configuration sequencer
package fbcs_pkg;
    typedef struct packed {
        logic       read_select_bit;
        logic       latency_high_reserved_bit;
        logic [2:0] first_access_latency_field;
        logic       reserved_bit_ten;
        logic       inter_beat_latency_bit;
        logic       ready_timing_bit;
        logic       burst_ordering_bit;
        logic       active_edge_bit;
        logic [1:0] reserved_mid_bits;
        logic       wrap_disable_bit;
        logic [2:0] burst_length_field;
    } fbcs_cfg_t;

    typedef struct packed {
        logic chip_en_n;
        logic out_en_n;
        logic wr_en_n;
        logic latch_n;
        logic adv_n;
        logic burst_clk;
    } fbcs_ctl_t;

    typedef enum logic [1:0] {
        FBCS_MODE_ARRAY,
        FBCS_MODE_SIG,
        FBCS_MODE_CFG_SETUP
    } fbcs_mode_t;

    typedef enum logic [1:0] {
        FBCS_ST_IDLE,
        FBCS_ST_LAT,
        FBCS_ST_DATA,
        FBCS_ST_WAIT
    } fbcs_state_t;
endpackage

// ===== logic/fbcs_top.sv
// Burst configuration register, command decode and burst address sequencer
// Notes on behaviour
// - Length code sets four, eight or continuous
// - Four/eight both orders; continuous sequential only
// - Aligned continuous burst never drops ready
// - Unaligned continuous burst drops ready for fetch
// - Continuous and no-wrap drop ready when delayed
// - Read select: 0 burst, 1 async, reset 1
// - Latency codes 010..110 give 4..8 clocks
// - Inter-beat bit: data every one or two
// - Ready timing bit moves low one cycle earlier
// - Active edge bit: 0 falling, 1 rising
// - Four-word order sequential or start xor beat
// - Eight-word order modulo eight; continuous linear
// - Bus writes go to command decode, except the data write after config setup
// - Read-array command selects array data reads
// - Signature command returns codes or configuration
// - Ordering bit: 0 interleaved, 1 sequential
// - Wrap disable bit: 0 wrap, 1 cross
// - Ready low stops data and address advance
// - Configuration kept until rewrite, reset, power-down
`include "fbcs_defs.svh"
module fbcs_top
    import fbcs_pkg::*;
#(
    parameter int          ADDR_W     = 19,
    parameter int          DATA_W     = 32,
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5a01 // Arbitrary value
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Flash pins
    input  wire logic              chip_en_n,
    input  wire logic              out_en_n,
    input  wire logic              wr_en_n,
    input  wire logic              latch_n,
    input  wire logic              adv_n,
    input  wire logic              burst_clk,
    input  wire logic              rp_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    output logic                   ready,
    // Array read port
    output logic      [ADDR_W-1:0] arr_addr,
    input  wire logic [DATA_W-1:0] arr_data,
    // Configuration view
    output logic      [15:0]       cfg_out
);
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Pin synchronisers; stage one feeds only stage two
    fbcs_ctl_t         ctl_s1_q, ctl_q, ctl_prev_q;
    logic              rp_s1_q, rp_q;
    logic [ADDR_W-1:0] addr_s1_q, addr_q;
    logic [DATA_W-1:0] dq_s1_q, dq_q;
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            // Idle pin levels with burst clock low, so no false edge follows reset
            ctl_s1_q   <= fbcs_ctl_t'(`FBCS_CTL_IDLE);
            ctl_q      <= fbcs_ctl_t'(`FBCS_CTL_IDLE);
            ctl_prev_q <= fbcs_ctl_t'(`FBCS_CTL_IDLE);
            rp_s1_q    <= 1'b0;
            rp_q       <= 1'b0;
            addr_s1_q  <= '0;
            addr_q     <= '0;
            dq_s1_q    <= '0;
            dq_q       <= '0;
        end else begin
            ctl_s1_q   <= '{chip_en_n, out_en_n, wr_en_n, latch_n, adv_n, burst_clk};
            ctl_q      <= ctl_s1_q;
            ctl_prev_q <= ctl_q;
            rp_s1_q    <= rp_n;
            rp_q       <= rp_s1_q;
            addr_s1_q  <= addr;
            addr_q     <= addr_s1_q;
            dq_s1_q    <= dq_in;
            dq_q       <= dq_s1_q;
        end
    end

    // Next address of a burst from the current one
    function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] cur,
                                                     input logic [2:0]        start,
                                                     input logic [2:0]        beat,
                                                     input fbcs_cfg_t         cfg);
        logic [2:0] mask;
        logic [2:0] off;
        mask = (cfg.burst_length_field == `FBCS_LEN_EIGHT) ? 3'h7 : 3'h3;
        off  = cfg.burst_ordering_bit ? ((start + beat) & mask) : ((start ^ beat) & mask);
        if (burst_linear(cfg)) begin
            burst_next = cur + {{(ADDR_W-1){1'b0}}, 1'b1};
        end else begin
            burst_next = {cur[ADDR_W-1:3], (cur[2:0] & ~mask) | off};
        end
    endfunction

    // Linear stepping: no wrap, or continuous length
    function automatic logic burst_linear(input fbcs_cfg_t cfg);
        burst_linear = cfg.wrap_disable_bit || (cfg.burst_length_field == `FBCS_LEN_CONT);
    endfunction

    // Latency code to clocks; reserved codes clamp into the legal range
    function automatic logic [3:0] lat_clocks(input logic [2:0] code);
        logic [2:0] c;
        c = code;
        if (c < `FBCS_LAT_MIN) begin
            c = `FBCS_LAT_MIN;
        end
        if (c > `FBCS_LAT_MAX) begin
            c = `FBCS_LAT_MAX;
        end
        lat_clocks = {1'b0, c} + `FBCS_LAT_BIAS;
    endfunction

    // Command interpreter and configuration
    fbcs_cfg_t  cfg_q, cfg_d;
    fbcs_mode_t mode_q, mode_d;
    logic       wr_done;
    assign wr_done = ctl_q.wr_en_n && !ctl_prev_q.wr_en_n && !ctl_q.chip_en_n;

    always_comb begin
        cfg_d  = cfg_q;
        mode_d = mode_q;
        if (!rp_q) begin
            cfg_d  = fbcs_cfg_t'(`FBCS_CFG_RESET);
            mode_d = FBCS_MODE_ARRAY;
        end else if (wr_done) begin
            if (mode_q == FBCS_MODE_CFG_SETUP) begin
                // Reserved bits are forced to zero whatever the host sends
                cfg_d  = fbcs_cfg_t'(dq_q[15:0] & `FBCS_CFG_WRITE_MASK);
                mode_d = FBCS_MODE_ARRAY;
            end else begin
                case (dq_q[7:0])
                    `FBCS_CMD_READ_ARRAY: mode_d = FBCS_MODE_ARRAY;
                    `FBCS_CMD_SIGNATURE:  mode_d = FBCS_MODE_SIG;
                    `FBCS_CMD_CFG_SETUP:  mode_d = FBCS_MODE_CFG_SETUP;
                    default:              mode_d = mode_q;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_q  <= fbcs_cfg_t'(`FBCS_CFG_RESET);
            mode_q <= FBCS_MODE_ARRAY;
        end else begin
            cfg_q  <= cfg_d;
            mode_q <= mode_d;
        end
    end

    // Burst sequencer
    fbcs_state_t       state_q, state_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [2:0]        start_q, start_d;
    logic [2:0]        beat_q, beat_d;
    logic [ADDR_W-1:0] cur_q, cur_d;
    logic              ytog_q, ytog_d;
    logic              waited_q, waited_d;
    logic              kedge;
    logic              sync_mode;
    logic              cross_due;

    // Burst clock is sampled, so it must run well below the system clock
    assign kedge     = cfg_q.active_edge_bit ? (ctl_q.burst_clk && !ctl_prev_q.burst_clk)
                                             : (!ctl_q.burst_clk && ctl_prev_q.burst_clk);
    assign sync_mode = !cfg_q.read_select_bit;
    // Unaligned linear burst needs one fetch pause at its first 8-word crossing
    assign cross_due = burst_linear(cfg_q) && (start_q != 3'h0) && !waited_q && (cur_q[2:0] == 3'h7);

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        start_d  = start_q;
        beat_d   = beat_q;
        cur_d    = cur_q;
        ytog_d   = ytog_q;
        waited_d = waited_q;
        if (!rp_q || ctl_q.chip_en_n || !sync_mode) begin
            state_d = FBCS_ST_IDLE;
        end else if (kedge && !ctl_q.latch_n) begin
            state_d  = FBCS_ST_LAT;
            cur_d    = addr_q;
            start_d  = addr_q[2:0];
            beat_d   = 3'h0;
            cnt_d    = lat_clocks(cfg_q.first_access_latency_field) - 4'h1;
            ytog_d   = 1'b0;
            waited_d = 1'b0;
        end else if (kedge) begin
            case (state_q)
                FBCS_ST_LAT: begin
                    if (cnt_q <= 4'h1) begin
                        state_d = FBCS_ST_DATA;
                    end else begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
                FBCS_ST_DATA: begin
                    if (!ctl_q.adv_n) begin
                        if (cfg_q.inter_beat_latency_bit && !ytog_q) begin
                            ytog_d = 1'b1;
                        end else if (cross_due) begin
                            state_d  = FBCS_ST_WAIT;
                            cnt_d    = `FBCS_WAIT_EDGES;
                            waited_d = 1'b1;
                            ytog_d   = 1'b0;
                        end else begin
                            ytog_d = 1'b0;
                            beat_d = beat_q + 3'h1;
                            cur_d  = burst_next(cur_q, start_q, beat_q + 3'h1, cfg_q);
                        end
                    end
                end
                FBCS_ST_WAIT: begin
                    // Address holds here even with advance low
                    if (cnt_q <= 4'h1) begin
                        state_d = FBCS_ST_DATA;
                        beat_d  = beat_q + 3'h1;
                        cur_d   = burst_next(cur_q, start_q, beat_q + 3'h1, cfg_q);
                    end else begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
                default: state_d = FBCS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q  <= FBCS_ST_IDLE;
            cnt_q    <= 4'h0;
            start_q  <= 3'h0;
            beat_q   <= 3'h0;
            cur_q    <= '0;
            ytog_q   <= 1'b0;
            waited_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            start_q  <= start_d;
            beat_q   <= beat_d;
            cur_q    <= cur_d;
            ytog_q   <= ytog_d;
            waited_q <= waited_d;
        end
    end

    // Output stage
    logic [DATA_W-1:0] dq_out_q, dq_out_d;
    logic              dq_oe_q, dq_oe_d;
    logic              ready_q, ready_d;
    logic [ADDR_W-1:0] arr_addr_q, arr_addr_d;
    logic              in_burst;
    assign in_burst = (state_q == FBCS_ST_DATA) || (state_q == FBCS_ST_WAIT);

    always_comb begin
        arr_addr_d = sync_mode ? cur_q : addr_q;
        dq_out_d   = dq_out_q;
        if (in_burst && state_q == FBCS_ST_WAIT) begin
            dq_out_d = dq_out_q;
        end else if (mode_q == FBCS_MODE_SIG) begin
            case (addr_q[2:0])
                `FBCS_SIG_MAKER_ADDR:  dq_out_d = {{(DATA_W-16){1'b0}}, MAKER_CODE};
                `FBCS_SIG_DEVICE_ADDR: dq_out_d = {{(DATA_W-16){1'b0}}, DEVICE_CODE};
                `FBCS_SIG_CFG_ADDR:    dq_out_d = {{(DATA_W-16){1'b0}}, cfg_q};
                default:               dq_out_d = '0;
            endcase
        end else begin
            dq_out_d = arr_data;
        end
        dq_oe_d = rp_q && !ctl_q.chip_en_n && !ctl_q.out_en_n && ctl_q.wr_en_n && (!sync_mode || in_burst);
        ready_d = 1'b1;
        if (state_q == FBCS_ST_WAIT) begin
            ready_d = 1'b0;
        end else if (state_q == FBCS_ST_DATA && cfg_q.ready_timing_bit && cross_due) begin
            ready_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dq_out_q   <= '0;
            dq_oe_q    <= 1'b0;
            ready_q    <= 1'b1;
            arr_addr_q <= '0;
        end else begin
            dq_out_q   <= dq_out_d;
            dq_oe_q    <= dq_oe_d;
            ready_q    <= ready_d;
            arr_addr_q <= arr_addr_d;
        end
    end

    assign dq_out   = dq_out_q;
    assign dq_oe    = dq_oe_q;
    assign ready    = ready_q;
    assign arr_addr = arr_addr_q;
    assign cfg_out  = cfg_q;
endmodule

// ===== dv/fbcs_top_chk.sv
// Pin-level assertions for the burst configuration sequencer
module fbcs_top_chk
#(
    parameter int ADDR_W = 19
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset_n,
    // Flash pins
    input wire logic              chip_en_n,
    input wire logic              out_en_n,
    input wire logic              wr_en_n,
    input wire logic              rp_n,
    input wire logic              dq_oe,
    input wire logic              ready,
    // Array and configuration
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [15:0]       cfg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_cfg_reserved_zero: assert property (cfg_out[14] == 1'b0 && cfg_out[10] == 1'b0 && cfg_out[5:4] == 2'h0)
        else $error("reserved configuration bit set");
    a_cfg_rp_default: assert property (!rp_n [*4] |=> cfg_out == 16'h8000)
        else $error("configuration not restored by power-down");
    a_cfg_hold_idle: assert property ((wr_en_n && rp_n) [*8] |=> $stable(cfg_out))
        else $error("configuration changed without a write");
    a_ready_async: assert property (cfg_out[15] && $past(cfg_out[15]) |-> ready)
        else $error("ready low in asynchronous mode");
    a_ready_low_bound: assert property ($fell(ready) |-> ##[1:60] ready)
        else $error("wait state too long");
    a_read_oe_async: assert property ((cfg_out[15] && !chip_en_n && !out_en_n && wr_en_n) [*6] |-> dq_oe)
        else $error("asynchronous read not driven");
    a_addr_hold_wait: assert property (!ready && $past(!ready) && !cfg_out[8] |-> $stable(arr_addr))
        else $error("address moved during wait");
    a_wrap_no_wait: assert property (!cfg_out[3] && cfg_out[2:0] != 3'h7 && $stable(cfg_out) |-> ready)
        else $error("wait state in wrapping burst");
    a_rp_ready: assert property (!rp_n [*4] |=> ready)
        else $error("power-down left ready low");

    c_wait_seen: cover property ($fell(ready));
    c_burst_data: cover property (dq_oe && !cfg_out[15]);
    c_rp_restore: cover property (!rp_n ##4 cfg_out == 16'h8000);
    c_early_ready: cover property (!ready && cfg_out[8] && !cfg_out[15]);
endmodule

bind fbcs_top fbcs_top_chk #(.ADDR_W(ADDR_W)) chk_u (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .chip_en_n (chip_en_n),
    .out_en_n  (out_en_n),
    .wr_en_n   (wr_en_n),
    .rp_n      (rp_n),
    .dq_oe     (dq_oe),
    .ready     (ready),
    .arr_addr  (arr_addr),
    .cfg_out   (cfg_out)
);

// ===== dv/fbcs_host_bfm.sv
// Host burst controller model driving the flash pins
module fbcs_host_bfm
    import fbcs_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Flash pins
    output fbcs_ctl_t        ctl,
    output logic      [18:0] addr,
    output logic      [31:0] dq_in,
    input  wire logic [31:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ctl = 6'b111110;
        addr = 19'h0;
        dq_in = 32'h0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Reserved bits zero, latency four, continuous only sequential
    function automatic fbcs_cfg_t mk_cfg(input logic seq, input logic nowrap, input logic [2:0] len);
        mk_cfg = '0;
        mk_cfg.first_access_latency_field = 3'h2;
        mk_cfg.burst_ordering_bit = seq | (len == 3'h7);
        mk_cfg.active_edge_bit = 1'b1;
        mk_cfg.wrap_disable_bit = nowrap;
        mk_cfg.burst_length_field = len;
    endfunction

    task automatic wr(input logic [18:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        ctl.chip_en_n <= 1'b0;
        ctl.wr_en_n <= 1'b0;
        addr <= a;
        dq_in <= d;
        step(4);
        ctl.wr_en_n <= 1'b1;
        step(4);
        ctl.chip_en_n <= 1'b1;
        // Released bus shows the inverse so stale data cannot pass
        dq_in <= ~d;
        step(4);
    endtask

    task automatic rd(input logic [18:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        ctl.chip_en_n <= 1'b0;
        ctl.out_en_n <= 1'b0;
        addr <= a;
        step(8);
        d = dq_out;
        ctl.chip_en_n <= 1'b1;
        ctl.out_en_n <= 1'b1;
        step(4);
    endtask

    // Burst clock runs only inside a burst, four system clocks per half
    task automatic ktick;
        step(4);
        ctl.burst_clk <= 1'b1;
        step(4);
        ctl.burst_clk <= 1'b0;
    endtask

    task automatic burst(input logic [18:0] a, input int n);
        @(posedge sys_clk);
        ctl.chip_en_n <= 1'b0;
        ctl.latch_n <= 1'b0;
        addr <= a;
        ktick();
        // Latch held past the falling edge as well
        step(2);
        ctl.latch_n <= 1'b1;
        ctl.adv_n <= 1'b0;
        ctl.out_en_n <= 1'b0;
        repeat (n) ktick();
        step(1);
        ctl <= 6'b111110;
        step(6);
    endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the burst configuration sequencer
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top
    import fbcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER  = 16'h1234; // Arbitrary value
    localparam logic [15:0] DEVICE = 16'h4321; // Arbitrary value

    logic        sys_clk;
    logic        reset_n;
    logic        rp_n;
    fbcs_ctl_t   ctl;
    logic [18:0] addr;
    logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic        dq_oe;
    logic        ready;
    logic [18:0] arr_addr;
    logic [31:0] arr_data;
    logic [15:0] cfg_out;
    logic [31:0] d;
    logic [18:0] seen_q[$];
    logic        low_seen;
    logic        cap;
    int          low_cnt;
    int          fail_count;
    int          checks_done;

    assign arr_data = {13'h0, arr_addr} ^ 32'h5a5a_0000;

    fbcs_top #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .chip_en_n(ctl.chip_en_n), .out_en_n(ctl.out_en_n),
        .wr_en_n(ctl.wr_en_n), .latch_n(ctl.latch_n), .adv_n(ctl.adv_n), .burst_clk(ctl.burst_clk),
        .rp_n(rp_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .ready(ready),
        .arr_addr(arr_addr), .arr_data(arr_data), .cfg_out(cfg_out));
    fbcs_host_bfm host_u (.sys_clk(sys_clk), .ctl(ctl), .addr(addr), .dq_in(dq_in), .dq_out(dq_out));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Records each new burst address while data is driven
    always @(posedge sys_clk) begin
        if (cap && dq_oe === 1'b1 && (seen_q.size() == 0 || arr_addr !== seen_q[$]))
            seen_q.push_back(arr_addr);
        if (cap && ready === 1'b0) begin
            low_seen = 1'b1;
            low_cnt++;
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic run_burst(input logic seq, input logic nowrap, input logic [2:0] len, input logic [18:0] st,
                             input logic [15:0] x);
        logic [18:0] e;
        logic [18:0] m;
        m = (len == 3'h2) ? 19'h7 : 19'h3;
        host_u.wr(19'h0, 32'h60);
        host_u.wr(19'h0, {16'h0, host_u.mk_cfg(seq, nowrap, len) ^ x});
        seen_q.delete();
        low_seen = 1'b0;
        low_cnt = 0;
        cap = 1'b1;
        host_u.burst(st, 14);
        cap = 1'b0;
        for (int b = 0; b < 5; b++) begin
            e = seq ? ((st & ~m) | ((st + 19'(b)) & m)) : ((st & ~m) | ((st ^ 19'(b)) & m));
            if (nowrap || len == 3'h7)
                e = st + 19'(b);
            `CHK("burst address", e, seen_q[b])
        end
        `CHK("wait state", (nowrap || len == 3'h7) && st[2:0] != 3'h0, low_seen)
        $display("burst test from %h done", st);
    endtask

    initial begin
        reset_n = 1'b0;
        rp_n = 1'b1;
        fail_count = 0;
        checks_done = 0;
        cap = 1'b0;
        low_seen = 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK("cfg reset", 16'h8000, cfg_out)
        `CHK("ready reset", 1'b1, ready)
        host_u.wr(19'h0, 32'h90);
        host_u.rd(19'h0, d);
        `CHK("maker code", {16'h0, MAKER}, d)
        host_u.rd(19'h5, d);
        `CHK("cfg view", 32'h8000, d)
        host_u.wr(19'h0, 32'h12);
        host_u.rd(19'h1, d);
        `CHK("device code", {16'h0, DEVICE}, d)
        host_u.wr(19'h0, 32'hff);
        host_u.rd(19'h3, d);
        `CHK("array data", 32'h5a5a_0003, d)
        host_u.wr(19'h0, 32'h60);
        host_u.wr(19'h0, 32'hb3cf);
        host_u.wr(19'h0, 32'h90);
        host_u.rd(19'h5, d);
        `CHK("cfg written", 32'hb3cf, d)
        $display("command test done");
        run_burst(1'b1, 1'b0, 3'h1, 19'h31, 16'h0);
        run_burst(1'b0, 1'b0, 3'h1, 19'h31, 16'h0);
        run_burst(1'b1, 1'b0, 3'h2, 19'h5, 16'h0);
        run_burst(1'b0, 1'b0, 3'h2, 19'h5, 16'h0);
        run_burst(1'b1, 1'b1, 3'h1, 19'h45, 16'h0);
        run_burst(1'b1, 1'b0, 3'h7, 19'h48, 16'h0);
        run_burst(1'b1, 1'b0, 3'h7, 19'h43, 16'h0);
        // Half-rate beats, early ready, falling active edge
        run_burst(1'b1, 1'b0, 3'h7, 19'h45, 16'h0340);
        `CHK("half-rate beats", 5, seen_q.size())
        `CHK("early ready", 1'b1, low_cnt > 24)
        @(posedge sys_clk);
        rp_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK("cfg power-down", 16'h8000, cfg_out)
        rp_n <= 1'b1;
        $display("power-down test done");
        report_and_stop();
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        fail_count++;
        report_and_stop();
    end
endmodule
